/* design/cldc_pkg.sv */
package cldc_pkg;

	// ------------------------------------------------------------
	// register map (byte-wide registers, 4-bit index)
	// ------------------------------------------------------------
	localparam int unsigned CLDC_ADDR_W   = 4;
	localparam int unsigned CLDC_DATA_W   = 8;
	localparam logic [3:0]  CLDC_ERR_CTRL = 4'h0;
	localparam logic [3:0]  CLDC_ERR_HIGH = 4'h1;
	localparam logic [3:0]  CLDC_ERR_LOW  = 4'h2;
	localparam logic [3:0]  CLDC_LOOP     = 4'h3;
	localparam logic [3:0]  CLDC_DETECT   = 4'h4;
	localparam logic [3:0]  CLDC_STATUS   = 4'h5;
	localparam logic [3:0]  CLDC_INT_FLAG = 4'h6;
	localparam logic [3:0]  CLDC_INT_MASK = 4'h7;
	localparam logic [3:0]  CLDC_MONITOR  = 4'h8;
	localparam logic [3:0]  CLDC_JM_CTRL  = 4'h9;
	localparam logic [3:0]  CLDC_POS_HIGH = 4'ha;
	localparam logic [3:0]  CLDC_POS_LOW  = 4'hb;
	localparam logic [3:0]  CLDC_NEG_HIGH = 4'hc;
	localparam logic [3:0]  CLDC_NEG_LOW  = 4'hd;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int unsigned CLDC_B_SNAP    = 0;
	localparam int unsigned CLDC_B_CNTAUTO = 1;
	localparam int unsigned CLDC_B_ALP     = 0;
	localparam int unsigned CLDC_B_RLP     = 1;
	localparam int unsigned CLDC_B_DLP     = 2;
	localparam int unsigned CLDC_B_AUTO_LOOP_EN  = 3;
	localparam int unsigned CLDC_B_DIR     = 3;
	localparam int unsigned CLDC_B_AUTOST  = 7;
	localparam int unsigned CLDC_B_OVF     = 0;
	localparam int unsigned CLDC_B_TICK    = 1;
	localparam int unsigned CLDC_B_JBW     = 0;
	localparam int unsigned CLDC_B_JAUTO   = 1;
	localparam int unsigned CLDC_B_JSTOP   = 2;
	localparam int unsigned CLDC_MON_W     = 6;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0] CLDC_CTRL_RST = 8'h00;
	localparam logic [1:0] CLDC_MASK_RST = 2'h3;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int unsigned CLDC_CLK_MHZ      = 200;
	localparam int unsigned CLDC_SECOND_MS    = 1000;
	localparam int unsigned CLDC_AUTO_LOOP_MS = 5100;
	localparam int unsigned CLDC_SECOND_CYC   = CLDC_SECOND_MS * 1000 * CLDC_CLK_MHZ;
	localparam int unsigned CLDC_AUTO_LOOP_CYC = CLDC_AUTO_LOOP_MS * 1000 * CLDC_CLK_MHZ;

	typedef enum logic {CLDC_LOOP_OFF, CLDC_LOOP_ON} cldc_loop_e;

endpackage : cldc_pkg

/* design/cldc_autoloop.sv */
`timescale 1ns/1ps
module cldc_autoloop
	import cldc_pkg::*;
#(
	parameter int unsigned HOLD_CYC = CLDC_AUTO_LOOP_CYC
) (
	input  wire logic clock_i,
	input  wire logic arst_n_i,
	input  wire logic enable_i,
	input  wire logic activate_i,
	input  wire logic deactivate_i,
	output logic      active_o
);

	localparam logic [31:0] HOLD_LAST = 32'(HOLD_CYC - 1);

	cldc_loop_e  state_r;
	logic [31:0] hold_cnt_r;
	wire         code_seen = (state_r == CLDC_LOOP_OFF) ? activate_i : deactivate_i;
	wire         hold_done = code_seen && (hold_cnt_r == HOLD_LAST);

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_r    <= CLDC_LOOP_OFF;
			hold_cnt_r <= 32'h0;
		end else if (!enable_i) begin
			state_r    <= CLDC_LOOP_OFF;
			hold_cnt_r <= 32'h0;
		end else if (!code_seen) begin
			hold_cnt_r <= 32'h0;
		end else if (hold_done) begin
			hold_cnt_r <= 32'h0;
			case (state_r)
				CLDC_LOOP_OFF: state_r <= CLDC_LOOP_ON;
				default:       state_r <= CLDC_LOOP_OFF;
			endcase
		end else begin
			hold_cnt_r <= hold_cnt_r + 32'h1;
		end
	end

	assign active_o = (state_r == CLDC_LOOP_ON);

endmodule : cldc_autoloop

/* design/cldc_err_counter.sv */
`timescale 1ns/1ps
module cldc_err_counter
	import cldc_pkg::*;
#(
	parameter int unsigned CNT_W = 16
) (
	input  wire logic             clock_i,
	input  wire logic             arst_n_i,
	input  wire logic             err_event_i,
	input  wire logic             snapshot_i,
	output logic      [CNT_W-1:0] hold_o,
	output logic                  overflow_o
);

	logic [CNT_W-1:0] count_r;
	logic [CNT_W-1:0] hold_r;
	logic             overflow_r;
	wire              count_full = &count_r;

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			count_r    <= '0;
			hold_r     <= '0;
			overflow_r <= 1'b0;
		end else begin
			overflow_r <= err_event_i && count_full && !snapshot_i;
			if (snapshot_i) begin
				hold_r  <= count_r;
				// an error in the snapshot cycle opens the new round
				count_r <= {{(CNT_W-1){1'b0}}, err_event_i};
			end else if (err_event_i && !count_full) begin
				count_r <= count_r + 1'b1;
			end
		end
	end

	assign hold_o     = hold_r;
	assign overflow_o = overflow_r;

endmodule : cldc_err_counter

/* design/cldc_top.sv */
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module cldc_top
	import cldc_pkg::*;
#(
	parameter int unsigned SECOND_CYC    = CLDC_SECOND_CYC,
	parameter int unsigned AUTO_LOOP_CYC = CLDC_AUTO_LOOP_CYC,
	parameter int unsigned PEAK_W        = 16
) (
	input  wire logic                   clock_i,
	input  wire logic                   arst_n_i,
	input  wire logic [CLDC_ADDR_W-1:0] reg_addr_i,
	input  wire logic [CLDC_DATA_W-1:0] reg_wdata_i,
	input  wire logic                   reg_wr_i,
	input  wire logic                   reg_rd_i,
	output logic      [CLDC_DATA_W-1:0] reg_rdata_o,
	input  wire logic                   bit_strobe_i,
	input  wire logic                   rx_line_pos_i,
	input  wire logic                   rx_line_neg_i,
	input  wire logic [1:0]             rx_data_i,
	input  wire logic [1:0]             rx_ja_i,
	input  wire logic [1:0]             tx_ja_i,
	input  wire logic [1:0]             tx_sys_i,
	input  wire logic                   rx_pat_en_i,
	input  wire logic [1:0]             rx_pat_i,
	input  wire logic                   tx_pat_en_i,
	input  wire logic [1:0]             tx_pat_i,
	input  wire logic                   rx_ais_en_i,
	input  wire logic                   tx_ais_en_i,
	input  wire logic [1:0]             ais_i,
	input  wire logic                   ib_activate_i,
	input  wire logic                   ib_deactivate_i,
	input  wire logic                   err_event_i,
	input  wire logic                   jitter_valid_i,
	input  wire logic [PEAK_W-1:0]      jitter_pos_i,
	input  wire logic [PEAK_W-1:0]      jitter_neg_i,
	output logic                        tx_line_pos_o,
	output logic                        tx_line_neg_o,
	output logic      [1:0]             rx_decode_o,
	output logic      [1:0]             rx_system_o,
	output logic      [1:0]             rx_detect_o,
	output logic      [1:0]             tx_detect_o,
	output logic                        tx_clock_ignore_o,
	output logic      [CLDC_MON_W-1:0]  monitor_select_o,
	output logic                        ext_match_force_o,
	output logic                        jitter_bandwidth_sel_o,
	output logic                        int_n_o
);

	localparam logic [31:0] SECOND_LAST = 32'(SECOND_CYC - 1);

	// ------------------------------------------------------------
	// register bus decode
	// ------------------------------------------------------------
	wire wr_err_ctrl = reg_wr_i && (reg_addr_i == CLDC_ERR_CTRL);
	wire wr_loop     = reg_wr_i && (reg_addr_i == CLDC_LOOP);
	wire wr_detect   = reg_wr_i && (reg_addr_i == CLDC_DETECT);
	wire wr_int_flag = reg_wr_i && (reg_addr_i == CLDC_INT_FLAG);
	wire wr_int_mask = reg_wr_i && (reg_addr_i == CLDC_INT_MASK);
	wire wr_monitor  = reg_wr_i && (reg_addr_i == CLDC_MONITOR);
	wire wr_jm_ctrl  = reg_wr_i && (reg_addr_i == CLDC_JM_CTRL);

	logic [1:0]            err_ctrl_r;
	logic [3:0]            loop_ctrl_r;
	logic                  detect_direction_r;
	logic [1:0]            int_flag_r;
	logic [1:0]            int_mask_r;
	logic [CLDC_MON_W-1:0] monitor_select_r;
	logic [2:0]            jm_ctrl_r;
	logic [PEAK_W-1:0]     pos_buf_r;
	logic [PEAK_W-1:0]     neg_buf_r;
	logic [PEAK_W-1:0]     pos_res_r;
	logic [PEAK_W-1:0]     neg_res_r;
	logic [31:0]           sec_cnt_r;
	logic                  second_tick_r;
	logic [CLDC_DATA_W-1:0] rdata_r;
	logic                  int_n_r;

	wire err_count_auto_mode  = err_ctrl_r[CLDC_B_CNTAUTO];
	wire analog_loop_en       = loop_ctrl_r[CLDC_B_ALP];
	wire remote_loop_en       = loop_ctrl_r[CLDC_B_RLP];
	wire digital_loop_en      = loop_ctrl_r[CLDC_B_DLP];
	wire auto_loop_en         = loop_ctrl_r[CLDC_B_AUTO_LOOP_EN];
	wire jitter_auto_mode     = jm_ctrl_r[CLDC_B_JAUTO];

	// manual snapshot triggers act on a written 0-to-1 change of the bit; auto mode uses the second tick
	wire err_manual_edge = wr_err_ctrl && reg_wdata_i[CLDC_B_SNAP] && !err_ctrl_r[CLDC_B_SNAP];
	wire jm_manual_edge  = wr_jm_ctrl && reg_wdata_i[CLDC_B_JSTOP] && !jm_ctrl_r[CLDC_B_JSTOP];
	wire err_snapshot = err_count_auto_mode ? second_tick_r : err_manual_edge;
	wire jm_snapshot  = jitter_auto_mode ? second_tick_r : jm_manual_edge;

	// ------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			err_ctrl_r         <= CLDC_CTRL_RST[1:0];
			loop_ctrl_r        <= CLDC_CTRL_RST[3:0];
			detect_direction_r <= 1'b0;
			int_mask_r         <= CLDC_MASK_RST;
			monitor_select_r   <= CLDC_CTRL_RST[CLDC_MON_W-1:0];
			jm_ctrl_r          <= CLDC_CTRL_RST[2:0];
		end else begin
			if (wr_err_ctrl)
				err_ctrl_r <= reg_wdata_i[1:0];
			if (wr_loop)
				loop_ctrl_r <= reg_wdata_i[3:0];
			if (wr_detect)
				detect_direction_r <= reg_wdata_i[CLDC_B_DIR];
			if (wr_int_mask)
				int_mask_r <= reg_wdata_i[1:0];
			if (wr_monitor)
				monitor_select_r <= reg_wdata_i[CLDC_MON_W-1:0];
			if (wr_jm_ctrl)
				jm_ctrl_r <= reg_wdata_i[2:0];
		end
	end

	// ------------------------------------------------------------
	// one-second timer from the master clock
	// ------------------------------------------------------------
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sec_cnt_r     <= 32'h0;
			second_tick_r <= 1'b0;
		end else begin
			second_tick_r <= (sec_cnt_r == SECOND_LAST);
			if (sec_cnt_r == SECOND_LAST)
				sec_cnt_r <= 32'h0;
			else
				sec_cnt_r <= sec_cnt_r + 32'h1;
		end
	end

	// ------------------------------------------------------------
	// error counter
	// ------------------------------------------------------------
	logic [15:0] err_hold;
	logic        err_overflow;

	cldc_err_counter #(
		.CNT_W (16)
	) u_err_counter (
		.clock_i     (clock_i),
		.arst_n_i    (arst_n_i),
		.err_event_i (err_event_i),
		.snapshot_i  (err_snapshot),
		.hold_o      (err_hold),
		.overflow_o  (err_overflow)
	);

	// ------------------------------------------------------------
	// interrupt flags, set wins over a write-one clear
	// ------------------------------------------------------------
	wire tick_set = second_tick_r && (jitter_auto_mode || err_count_auto_mode);
	wire [1:0] flag_set = {tick_set, err_overflow};
	wire [1:0] flag_clr = wr_int_flag ? reg_wdata_i[1:0] : 2'h0;
	wire [1:0] flag_nxt = flag_set | (int_flag_r & ~flag_clr);

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			int_flag_r <= 2'h0;
			int_n_r    <= 1'b1;
		end else begin
			int_flag_r <= flag_nxt;
			int_n_r    <= ~|(flag_nxt & ~int_mask_r);
		end
	end

	// ------------------------------------------------------------
	// jitter peak buffers, values kept in 1/16 UI steps
	// ------------------------------------------------------------
	wire [PEAK_W-1:0] pos_in  = jitter_valid_i ? jitter_pos_i : '0;
	wire [PEAK_W-1:0] neg_in  = jitter_valid_i ? jitter_neg_i : '0;
	wire [PEAK_W-1:0] pos_max = (pos_in > pos_buf_r) ? pos_in : pos_buf_r;
	wire [PEAK_W-1:0] neg_max = (neg_in > neg_buf_r) ? neg_in : neg_buf_r;

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pos_buf_r <= '0;
			neg_buf_r <= '0;
			pos_res_r <= '0;
			neg_res_r <= '0;
		end else if (jm_snapshot) begin
			pos_res_r <= pos_max;
			neg_res_r <= neg_max;
			pos_buf_r <= '0;
			neg_buf_r <= '0;
		end else begin
			pos_buf_r <= pos_max;
			neg_buf_r <= neg_max;
		end
	end

	// ------------------------------------------------------------
	// automatic loopback
	// ------------------------------------------------------------
	logic auto_remote;
	logic auto_digital;

	// direction is assumed stable while an automatic loop runs
	cldc_autoloop #(
		.HOLD_CYC (AUTO_LOOP_CYC)
	) u_auto_remote (
		.clock_i      (clock_i),
		.arst_n_i     (arst_n_i),
		.enable_i     (auto_loop_en && !detect_direction_r),
		.activate_i   (ib_activate_i),
		.deactivate_i (ib_deactivate_i),
		.active_o     (auto_remote)
	);

	cldc_autoloop #(
		.HOLD_CYC (AUTO_LOOP_CYC)
	) u_auto_digital (
		.clock_i      (clock_i),
		.arst_n_i     (arst_n_i),
		.enable_i     (auto_loop_en && detect_direction_r),
		.activate_i   (ib_activate_i),
		.deactivate_i (ib_deactivate_i),
		.active_o     (auto_digital)
	);

	wire auto_loop_status = auto_remote || auto_digital;

	// ------------------------------------------------------------
	// loopback mode, committed only on a bit boundary
	// ------------------------------------------------------------
	wire analog_nxt  = analog_loop_en;
	wire remote_nxt  = !analog_loop_en && (remote_loop_en || auto_remote);
	wire digital_nxt = !analog_loop_en && (digital_loop_en || auto_digital);

	logic analog_r;
	logic remote_r;
	logic digital_r;

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			analog_r  <= 1'b0;
			remote_r  <= 1'b0;
			digital_r <= 1'b0;
		end else if (bit_strobe_i) begin
			analog_r  <= analog_nxt;
			remote_r  <= remote_nxt;
			digital_r <= digital_nxt;
		end
	end

	// ------------------------------------------------------------
	// line input synchroniser
	// ------------------------------------------------------------
	logic [1:0] line_meta_r;
	logic [1:0] line_sync_r;

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			line_meta_r <= 2'h0;
			line_sync_r <= 2'h0;
		end else begin
			line_meta_r <= {rx_line_pos_i, rx_line_neg_i};
			line_sync_r <= line_meta_r;
		end
	end

	// ------------------------------------------------------------
	// data path selection
	// ------------------------------------------------------------
	logic [1:0] tx_line_r;
	logic [1:0] rx_decode_r;
	logic [1:0] rx_system_r;
	logic [1:0] rx_detect_r;
	logic [1:0] tx_detect_r;

	// AIS loses to looped data, so any loop in its path blocks it
	wire rx_ais_ok = !analog_r && !digital_r;
	wire tx_ais_ok = !analog_r && !remote_r && !digital_r;

	wire [1:0] rx_in_sel = analog_r  ? tx_line_r :
	                       digital_r ? tx_ja_i   :
	                                   line_sync_r;
	wire [1:0] rx_sys_sel = rx_pat_en_i ? rx_pat_i :
	                        (rx_ais_en_i && rx_ais_ok) ? ais_i :
	                                     rx_data_i;
	wire [1:0] tx_sel = tx_pat_en_i ? tx_pat_i :
	                    remote_r    ? rx_ja_i  :
	                    (tx_ais_en_i && tx_ais_ok) ? ais_i :
	                                  tx_sys_i;
	// line detectors see the real line except under analog loop
	wire [1:0] rx_det_sel = analog_r ? tx_line_r : line_sync_r;

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tx_line_r   <= 2'h0;
			rx_decode_r <= 2'h0;
			rx_system_r <= 2'h0;
			rx_detect_r <= 2'h0;
		end else if (bit_strobe_i) begin
			tx_line_r   <= tx_sel;
			rx_decode_r <= rx_in_sel;
			rx_system_r <= rx_sys_sel;
			rx_detect_r <= rx_det_sel;
		end
	end

	// system-side detectors never see the looped stream
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i)
			tx_detect_r <= 2'h0;
		else
			tx_detect_r <= tx_sys_i;
	end

	// ------------------------------------------------------------
	// channel 0 monitoring and misc outputs
	// ------------------------------------------------------------
	logic                  tx_clock_ignore_r;
	logic [CLDC_MON_W-1:0] monitor_out_r;
	logic                  ext_match_r;
	logic                  jbw_r;

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tx_clock_ignore_r <= 1'b0;
			monitor_out_r     <= '0;
			ext_match_r       <= 1'b0;
			jbw_r             <= 1'b0;
		end else begin
			tx_clock_ignore_r <= remote_r;
			monitor_out_r     <= monitor_select_r;
			ext_match_r       <= |monitor_select_r;
			jbw_r             <= jm_ctrl_r[CLDC_B_JBW];
		end
	end

	// ------------------------------------------------------------
	// read path, data one cycle after the strobe
	// ------------------------------------------------------------
	wire [7:0] status_val = {auto_loop_status, 4'h0, digital_r, remote_r, analog_r};
	logic [7:0] rd_mux;

	always_comb begin
		rd_mux = 8'h00;
		if (reg_addr_i == CLDC_ERR_CTRL)
			rd_mux = {6'h00, err_ctrl_r};
		else if (reg_addr_i == CLDC_ERR_HIGH)
			rd_mux = err_hold[15:8];
		else if (reg_addr_i == CLDC_ERR_LOW)
			rd_mux = err_hold[7:0];
		else if (reg_addr_i == CLDC_LOOP)
			rd_mux = {4'h0, loop_ctrl_r};
		else if (reg_addr_i == CLDC_DETECT)
			rd_mux = {4'h0, detect_direction_r, 3'h0};
		else if (reg_addr_i == CLDC_STATUS)
			rd_mux = status_val;
		else if (reg_addr_i == CLDC_INT_FLAG)
			rd_mux = {6'h00, int_flag_r};
		else if (reg_addr_i == CLDC_INT_MASK)
			rd_mux = {6'h00, int_mask_r};
		else if (reg_addr_i == CLDC_MONITOR)
			rd_mux = {2'h0, monitor_select_r};
		else if (reg_addr_i == CLDC_JM_CTRL)
			rd_mux = {5'h00, jm_ctrl_r};
		else if (reg_addr_i == CLDC_POS_HIGH)
			rd_mux = pos_res_r[15:8];
		else if (reg_addr_i == CLDC_POS_LOW)
			rd_mux = pos_res_r[7:0];
		else if (reg_addr_i == CLDC_NEG_HIGH)
			rd_mux = neg_res_r[15:8];
		else if (reg_addr_i == CLDC_NEG_LOW)
			rd_mux = neg_res_r[7:0];
	end

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i)
			rdata_r <= 8'h00;
		else if (reg_rd_i)
			rdata_r <= rd_mux;
		else
			rdata_r <= 8'h00;
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign reg_rdata_o            = rdata_r;
	assign tx_line_pos_o          = tx_line_r[1];
	assign tx_line_neg_o          = tx_line_r[0];
	assign rx_decode_o            = rx_decode_r;
	assign rx_system_o            = rx_system_r;
	assign rx_detect_o            = rx_detect_r;
	assign tx_detect_o            = tx_detect_r;
	assign tx_clock_ignore_o      = tx_clock_ignore_r;
	assign monitor_select_o       = monitor_out_r;
	assign ext_match_force_o      = ext_match_r;
	assign jitter_bandwidth_sel_o = jbw_r;
	assign int_n_o                = int_n_r;

endmodule : cldc_top

/* test/cldc_far_end.sv */
`timescale 1ns/1ps
module cldc_far_end (
	input  wire logic       clock_i,
	output logic            strobe_o = 1'b0,
	output logic      [7:0] bits_o = 8'h00
);
	// ----
	// line side: one bit every third cycle
	// ----
	int cnt = 0;
	int seed = 27904;
	// data changes only on the strobe edge, so a bit is never cut short
	always @(posedge clock_i) begin
		cnt <= (cnt + 1) % 3;
		strobe_o <= (cnt == 2);
		if (strobe_o)
			bits_o <= $random(seed);
	end
endmodule : cldc_far_end

/* test/cldc_top_monitor.sv */
`timescale 1ns/1ps
module cldc_top_monitor
	import cldc_pkg::*;
(
	input wire logic                   clock_i,
	input wire logic                   arst_n_i,
	input wire logic [CLDC_ADDR_W-1:0] reg_addr_i,
	input wire logic [CLDC_DATA_W-1:0] reg_wdata_i,
	input wire logic                   reg_wr_i,
	input wire logic                   reg_rd_i,
	input wire logic [CLDC_DATA_W-1:0] reg_rdata_o,
	input wire logic                   bit_strobe_i,
	input wire logic                   rx_pat_en_i,
	input wire logic [1:0]             rx_pat_i,
	input wire logic                   tx_pat_en_i,
	input wire logic [1:0]             tx_pat_i,
	input wire logic [1:0]             tx_sys_i,
	input wire logic [1:0]             tx_detect_o,
	input wire logic                   tx_line_pos_o,
	input wire logic                   tx_line_neg_o,
	input wire logic [1:0]             rx_decode_o,
	input wire logic [1:0]             rx_system_o,
	input wire logic [CLDC_MON_W-1:0]  monitor_select_o,
	input wire logic                   ext_match_force_o,
	input wire logic                   int_n_o
);
	// ----
	// port relations
	// ----
	default clocking @(posedge clock_i); endclocking
	default disable iff (!arst_n_i);
	wire [1:0] tx_w = {tx_line_pos_o, tx_line_neg_o};
	a_path_hold: assert property (
		!$past(bit_strobe_i) |-> $stable({tx_w, rx_decode_o, rx_system_o}))
		else $error("loop data moved off a bit boundary");
	a_rx_pattern: assert property (
		bit_strobe_i && rx_pat_en_i |=> rx_system_o == $past(rx_pat_i))
		else $error("rx pattern not on system side");
	a_tx_pattern: assert property (
		bit_strobe_i && tx_pat_en_i |=> tx_w == $past(tx_pat_i))
		else $error("tx pattern not on line");
	a_tx_monitor: assert property (
		$past(arst_n_i) |-> tx_detect_o == $past(tx_sys_i))
		else $error("tx detectors lost system data");
	a_mon_force: assert property (
		ext_match_force_o == (|monitor_select_o))
		else $error("matching force wrong");
	a_mon_copy: assert property (
		reg_wr_i && reg_addr_i == CLDC_MONITOR |-> ##2
		monitor_select_o == $past(reg_wdata_i[5:0], 2))
		else $error("monitor select not applied");
	a_loop_excl: assert property (
		reg_rd_i && reg_addr_i == CLDC_STATUS |=> !(reg_rdata_o[0] && |reg_rdata_o[2:1]))
		else $error("analog loop beside another loop");
	// a flag clear releases the pin one cycle later, a mask write two
	a_int_release: assert property (
		$rose(int_n_o) |-> $past(reg_wr_i && reg_addr_i == CLDC_INT_FLAG) ||
		$past(reg_wr_i && reg_addr_i == CLDC_INT_MASK, 2))
		else $error("interrupt released without a write");
endmodule : cldc_top_monitor
bind cldc_top cldc_top_monitor u_mon (.clock_i, .arst_n_i, .reg_addr_i, .reg_wdata_i,
	.reg_wr_i, .reg_rd_i, .reg_rdata_o, .bit_strobe_i, .rx_pat_en_i, .rx_pat_i,
	.tx_pat_en_i, .tx_pat_i, .tx_sys_i, .tx_detect_o, .tx_line_pos_o, .tx_line_neg_o,
	.rx_decode_o, .rx_system_o, .monitor_select_o, .ext_match_force_o, .int_n_o);

/* test/cldc_top_tb_top.sv */
`timescale 1ns/1ps
module cldc_top_tb_top
	import cldc_pkg::*;
;
	logic        clock_i = 1'b0, arst_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
	logic [3:0]  reg_addr_i = 4'h0;
	logic [7:0]  reg_wdata_i = 8'h00, reg_rdata_o;
	logic        bit_strobe_i, rx_line_pos_i, rx_line_neg_i, tx_line_pos_o, tx_line_neg_o;
	logic [1:0]  rx_data_i, rx_ja_i, tx_ja_i, tx_sys_i = 2'h0, rx_pat_i = 2'h1;
	logic [1:0]  tx_pat_i = 2'h2, ais_i = 2'h3, rx_decode_o, rx_system_o, rx_detect_o;
	logic        rx_pat_en_i = 1'b0, tx_pat_en_i = 1'b0, rx_ais_en_i = 1'b1, tx_ais_en_i = 1'b1;
	logic        ib_activate_i = 1'b0, ib_deactivate_i = 1'b0, err_event_i = 1'b0;
	logic        jitter_valid_i = 1'b0, tx_clock_ignore_o, ext_match_force_o;
	logic        jitter_bandwidth_sel_o, int_n_o;
	logic [15:0] jitter_pos_i = 16'h0000, jitter_neg_i = 16'h0000, n, p, q, mp, mn;
	logic [1:0]  tx_detect_o;
	logic [5:0]  monitor_select_o;
	logic [2:0]  em [4] = '{3'b001, 3'b010, 3'b100, 3'b001};
	logic [7:0]  lp [4] = '{8'h01, 8'h02, 8'h04, 8'h07};
	int          miscompares = 0, total_checks = 0, seed = 27904;
	cldc_top #(.SECOND_CYC(20), .AUTO_LOOP_CYC(8)) DUT (.*);
	cldc_far_end u_far (.clock_i, .strobe_o(bit_strobe_i),
		.bits_o({rx_line_pos_i, rx_line_neg_i, rx_data_i, rx_ja_i, tx_ja_i}));
	always #2.5 clock_i = ~clock_i;
	// ----
	// bus and compare helpers
	// ----
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clock_i);
		reg_wr_i <= 1'b0;
		// spare edge, so back-to-back writes never set the strobe twice in one step
		@(posedge clock_i);
	endtask : wr
	task automatic rdc(input logic [3:0] a, input logic [7:0] e);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clock_i);
		reg_rd_i <= 1'b0;
		#1 check(reg_rdata_o, e);
		@(posedge clock_i);
	endtask : rdc
	task automatic errs(input logic [15:0] k);
		repeat (k) begin
			err_event_i <= 1'b1;
			@(posedge clock_i);
		end
		err_event_i <= 1'b0;
	endtask : errs
	// m is {digital, remote, analog}; expected bit built from the priorities
	task automatic lchk(input logic [2:0] m);
		logic [1:0] tl, rs, tj, ld;
		do begin @(posedge clock_i); #1; end while (bit_strobe_i !== 1'b1);
		tl = tx_pat_en_i ? tx_pat_i : m[1] ? rx_ja_i : tx_sys_i;
		rs = rx_pat_en_i ? rx_pat_i : m[1] ? ais_i : rx_data_i;
		tj = m[0] ? tl : tx_ja_i;
		ld = {rx_line_pos_i, rx_line_neg_i};
		@(posedge clock_i);
		#1 check({tx_line_pos_o, tx_line_neg_o}, tl);
		check(rx_system_o, rs);
		if (m[2] || m[0])
			check(rx_decode_o, tj);
		if (!m[0])
			check(rx_detect_o, ld);
		check(tx_clock_ignore_o, m[1]);
		@(posedge clock_i);
	endtask : lchk
	task automatic finish_test;
		$display("checks %0d miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : finish_test
	initial begin
		#450000 miscompares++;
		finish_test();
	end
	initial begin
		repeat (6) @(posedge clock_i);
		arst_n_i <= 1'b1;
		@(posedge clock_i);
		rdc(CLDC_INT_MASK, {6'h00, CLDC_MASK_RST});
		rdc(CLDC_LOOP, CLDC_CTRL_RST);
		rdc(4'hf, 8'h00);
		$display("reset done");
		repeat (2) begin
			n = 1 + {$random(seed)} % 40;
			errs(n);
			wr(CLDC_ERR_CTRL, 8'h00);
			wr(CLDC_ERR_CTRL, 8'h01);
			errs(5);
			repeat (30) @(posedge clock_i);
			rdc(CLDC_ERR_HIGH, n[15:8]);
			rdc(CLDC_ERR_LOW, n[7:0]);
			wr(CLDC_ERR_CTRL, 8'h00);
			wr(CLDC_ERR_CTRL, 8'h01);
			rdc(CLDC_ERR_LOW, 8'h05);
		end
		wr(CLDC_ERR_CTRL, 8'h00);
		errs(16'hffff);
		@(posedge clock_i);
		errs(1);
		wr(CLDC_ERR_CTRL, 8'h01);
		rdc(CLDC_ERR_HIGH, 8'hff);
		rdc(CLDC_INT_FLAG, 8'h01);
		check(int_n_o, 1'b1);
		wr(CLDC_INT_MASK, 8'h00);
		repeat (2) @(posedge clock_i);
		check(int_n_o, 1'b0);
		wr(CLDC_INT_FLAG, 8'h01);
		repeat (2) @(posedge clock_i);
		check(int_n_o, 1'b1);
		$display("counter done");
		foreach (lp[i]) begin
			tx_sys_i <= $random(seed);
			rx_pat_en_i <= i[0];
			tx_pat_en_i <= i[1];
			wr(CLDC_LOOP, lp[i]);
			repeat (12) @(posedge clock_i);
			rdc(CLDC_STATUS, {5'h00, em[i]});
			lchk(em[i]);
		end
		$display("loops done");
		for (int d = 0; d < 2; d++) begin
			wr(CLDC_LOOP, 8'h00);
			wr(CLDC_DETECT, d ? 8'h08 : 8'h00);
			wr(CLDC_LOOP, 8'h08);
			ib_activate_i <= 1'b1;
			repeat (20) @(posedge clock_i);
			ib_activate_i <= 1'b0;
			rdc(CLDC_STATUS, d ? 8'h84 : 8'h82);
			ib_deactivate_i <= 1'b1;
			repeat (20) @(posedge clock_i);
			ib_deactivate_i <= 1'b0;
			rdc(CLDC_STATUS, 8'h00);
		end
		ib_activate_i <= 1'b1;
		repeat (20) @(posedge clock_i);
		wr(CLDC_LOOP, 8'h00);
		repeat (6) @(posedge clock_i);
		rdc(CLDC_STATUS, 8'h00);
		ib_activate_i <= 1'b0;
		$display("auto loop done");
		mp = 16'h0000;
		mn = 16'h0000;
		repeat (10) begin
			p = $random(seed);
			q = $random(seed);
			jitter_pos_i <= p;
			jitter_neg_i <= q;
			jitter_valid_i <= 1'b1;
			mp = p > mp ? p : mp;
			mn = q > mn ? q : mn;
			@(posedge clock_i);
		end
		jitter_valid_i <= 1'b0;
		wr(CLDC_JM_CTRL, 8'h04);
		rdc(CLDC_POS_HIGH, mp[15:8]);
		rdc(CLDC_POS_LOW, mp[7:0]);
		rdc(CLDC_NEG_HIGH, mn[15:8]);
		rdc(CLDC_NEG_LOW, mn[7:0]);
		wr(CLDC_JM_CTRL, 8'h00);
		wr(CLDC_JM_CTRL, 8'h04);
		rdc(CLDC_POS_LOW, 8'h00);
		wr(CLDC_JM_CTRL, 8'h02);
		repeat (25) @(posedge clock_i);
		rdc(CLDC_INT_FLAG, 8'h02);
		check(int_n_o, 1'b0);
		wr(CLDC_MONITOR, 8'h01 + {$random(seed)} % 63);
		repeat (2) @(posedge clock_i);
		check(ext_match_force_o, 1'b1);
		wr(CLDC_ERR_CTRL, 8'h02);
		repeat (25) @(posedge clock_i);
		rdc(CLDC_ERR_HIGH, 8'h00);
		$display("jitter and monitor done");
		finish_test();
	end
endmodule : cldc_top_tb_top
